// ===== src/spu_pkg.sv
/*
  Constants for the four-mode serial port: register offsets, field positions,
  reset values, rate divisors and state enumerations.
  Assumes a 32-bit APB register bus and a 40 MHz oscillator clock.
*/
package spu_pkg;
  localparam int unsigned OSC_HZ          = 40_000_000;
  localparam logic [7:0]  ADDR_BUFFER     = 8'h00;
  localparam logic [7:0]  ADDR_CONTROL    = 8'h04;
  localparam logic [7:0]  ADDR_RATE       = 8'h08;
  localparam logic [7:0]  CONTROL_RESET   = 8'h00;
  localparam logic [2:0]  RATE_RESET      = 3'h0;
  localparam int unsigned BIT_MODE_HIGH   = 7;
  localparam int unsigned BIT_MODE_LOW    = 6;
  localparam int unsigned BIT_FILTER      = 5;
  localparam int unsigned BIT_RX_ENABLE   = 4;
  localparam int unsigned BIT_TX_NINTH    = 3;
  localparam int unsigned BIT_RX_NINTH    = 2;
  localparam int unsigned BIT_TX_DONE     = 1;
  localparam int unsigned BIT_RX_DONE     = 0;
  localparam int unsigned BIT_RATE_DOUBLE = 0;
  localparam int unsigned BIT_TX_TIMER_B  = 1;
  localparam int unsigned BIT_RX_TIMER_B  = 2;
  localparam logic [3:0]  SHIFT_DIV       = 4'hC;
  localparam logic [3:0]  SHIFT_LAST      = SHIFT_DIV - 4'h1;
  localparam logic [3:0]  SHIFT_RISE      = SHIFT_DIV >> 1;
  localparam logic [3:0]  OVERSAMPLE      = 4'hF;
  localparam logic [3:0]  OVERSAMPLE_MID  = 4'h7;
  localparam logic [1:0]  FIXED_SLOW_DIV  = 2'h3;
  localparam logic [1:0]  FIXED_FAST_DIV  = 2'h1;
  localparam logic [3:0]  FRAME8_LAST     = 4'h9;
  localparam logic [3:0]  FRAME9_LAST     = 4'hA;
  localparam logic [2:0]  SHIFT_BITS_LAST = 3'h7;

  typedef enum logic [1:0] {
    MODE_SHIFT = 2'h0,
    MODE_VAR8  = 2'h1,
    MODE_FIX9  = 2'h2,
    MODE_VAR9  = 2'h3
  } spu_mode_e;

  typedef enum {TX_IDLE, TX_ARM, TX_SHIFT, TX_ASYNC} spu_tx_e;
  typedef enum {RX_IDLE, RX_ARM, RX_SHIFT, RX_ASYNC} spu_rx_e;
endpackage : spu_pkg

// ===== src/spu_serial_port.sv
/*
  Four-mode serial port with APB register access: shift-register mode and
  8-bit or 9-bit asynchronous modes, receive-buffered, full duplex in the asynchronous modes.
  Assumes timer overflow pulses arrive one clock wide on the system clock and
  that the serial data input pin is asynchronous to it.
*/
// The register addresses and register access over APB are this design's own decisions.
`timescale 1ns/10ps
module spu_serial_port (
  input  wire logic        SYS_CLK_IN,
  input  wire logic        RST_B_IN,
  input  wire logic        PSEL_IN,
  input  wire logic        PENABLE_IN,
  input  wire logic        PWRITE_IN,
  input  wire logic [7:0]  PADDR_IN,
  input  wire logic [31:0] PWDATA_IN,
  output logic      [31:0] PRDATA_OUT,
  output logic             PREADY_OUT,
  output logic             PSLVERR_OUT,
  input  wire logic        TMR_A_OVF_IN,
  input  wire logic        TMR_B_OVF_IN,
  input  wire logic        RXD_IN,
  output logic             RXD_OUT,
  output logic             RXD_OE_OUT,
  output logic             TXD_OUT,
  output logic             IRQ_OUT
);
  import spu_pkg::*;

  logic [7:0]  control_q;
  logic [2:0]  rate_q;
  logic [7:0]  rx_buffer_q;
  logic        pready_q;
  logic [31:0] prdata_q;
  logic        pslverr_q;
  logic        rxd_meta_q;
  logic        rxd_sync_q;
  logic        rxd_prev_q;
  logic [3:0]  cyc_q;
  logic [1:0]  fix_div_q;
  logic        tmr_a_half_q;
  spu_tx_e     tx_st_q;
  spu_rx_e     rx_st_q;
  logic [10:0] tx_sh_q;
  logic [3:0]  tx_sub_q;
  logic [3:0]  tx_bit_q;
  logic [7:0]  rx_sh_q;
  logic [3:0]  rx_sub_q;
  logic [3:0]  rx_bit_q;
  logic        rx_ninth_q;
  logic        txd_q;
  logic        rxd_out_q;
  logic        rxd_oe_q;
  logic        irq_q;

  spu_mode_e   mode;
  logic        nine_bit;
  logic        access;
  logic        setup;
  logic        addr_ok;
  logic        buf_write;
  logic        ctl_write;
  logic        cyc_end;
  logic        fixed_tick;
  logic        tmr_a_tick;
  logic        tx_tick;
  logic        rx_tick;
  logic [3:0]  tx_last;
  logic [3:0]  rx_last;
  logic        tx_done_set;
  logic        rx_done_set;
  logic        rx_stop_seen;
  logic        rx_accept;
  logic        rx_ninth_in;
  logic [31:0] read_mux;

  assign mode     = spu_mode_e'({control_q[BIT_MODE_HIGH], control_q[BIT_MODE_LOW]});
  assign nine_bit = control_q[BIT_MODE_HIGH];
  assign setup    = PSEL_IN && PENABLE_IN && !pready_q;
  assign access   = PSEL_IN && PENABLE_IN && pready_q;
  assign addr_ok  = (PADDR_IN == ADDR_BUFFER) || (PADDR_IN == ADDR_CONTROL) ||
                    (PADDR_IN == ADDR_RATE);
  assign buf_write = access && PWRITE_IN && (PADDR_IN == ADDR_BUFFER);
  assign ctl_write = access && PWRITE_IN && (PADDR_IN == ADDR_CONTROL);

  // One wait state per access; the answer is registered so all bus outputs come from flops.
  always_ff @(posedge SYS_CLK_IN or negedge RST_B_IN) begin
    if (!RST_B_IN) begin
      pready_q  <= 1'b0;
      prdata_q  <= 32'h0000_0000;
      pslverr_q <= 1'b0;
    end else begin
      pready_q  <= setup;
      pslverr_q <= setup && !addr_ok;
      if (setup) prdata_q <= PWRITE_IN ? 32'h0000_0000 : read_mux;
    end
  end

  always_comb begin
    read_mux = 32'h0000_0000;
    case (PADDR_IN)
      ADDR_BUFFER:  read_mux = {24'h00_0000, rx_buffer_q};
      ADDR_CONTROL: read_mux = {24'h00_0000, control_q};
      ADDR_RATE:    read_mux = {29'h0, rate_q};
      default:      read_mux = 32'h0000_0000;
    endcase
  end

  always_ff @(posedge SYS_CLK_IN or negedge RST_B_IN) begin
    if (!RST_B_IN) begin
      rate_q <= RATE_RESET;
    end else if (access && PWRITE_IN && (PADDR_IN == ADDR_RATE)) begin
      rate_q <= PWDATA_IN[2:0];
    end
  end

  // Hardware sets win over a software clear arriving in the same cycle.
  always_ff @(posedge SYS_CLK_IN or negedge RST_B_IN) begin
    if (!RST_B_IN) begin
      control_q <= CONTROL_RESET;
    end else begin
      if (ctl_write) control_q <= PWDATA_IN[7:0];
      if (rx_accept) control_q[BIT_RX_NINTH] <= rx_ninth_in;
      if (tx_done_set) control_q[BIT_TX_DONE] <= 1'b1;
      if (rx_done_set) control_q[BIT_RX_DONE] <= 1'b1;
    end
  end

  always_ff @(posedge SYS_CLK_IN or negedge RST_B_IN) begin
    if (!RST_B_IN) begin
      rxd_meta_q <= 1'b1;
      rxd_sync_q <= 1'b1;
      rxd_prev_q <= 1'b1;
    end else begin
      rxd_meta_q <= RXD_IN;
      rxd_sync_q <= rxd_meta_q;
      rxd_prev_q <= rxd_sync_q;
    end
  end

  // Rate sources: machine cycle of twelve clocks, fixed /4 or /2 prescale for
  // sixteen-fold oversampling, and timer overflows.
  assign cyc_end    = (cyc_q == SHIFT_LAST);
  assign fixed_tick = (fix_div_q == 2'h0);
  assign tmr_a_tick = TMR_A_OVF_IN && (rate_q[BIT_RATE_DOUBLE] || tmr_a_half_q);

  always_ff @(posedge SYS_CLK_IN or negedge RST_B_IN) begin
    if (!RST_B_IN) begin
      cyc_q        <= 4'h0;
      fix_div_q    <= 2'h0;
      tmr_a_half_q <= 1'b0;
    end else begin
      cyc_q <= cyc_end ? 4'h0 : cyc_q + 4'h1;
      fix_div_q <= !fixed_tick ? fix_div_q - 2'h1 :
                   rate_q[BIT_RATE_DOUBLE] ? FIXED_FAST_DIV : FIXED_SLOW_DIV;
      if (TMR_A_OVF_IN) tmr_a_half_q <= !tmr_a_half_q;
    end
  end

  assign tx_tick = (mode == MODE_FIX9) ? fixed_tick :
                   rate_q[BIT_TX_TIMER_B] ? TMR_B_OVF_IN : tmr_a_tick;
  assign rx_tick = (mode == MODE_FIX9) ? fixed_tick :
                   rate_q[BIT_RX_TIMER_B] ? TMR_B_OVF_IN : tmr_a_tick;

  assign tx_last = nine_bit ? FRAME9_LAST : FRAME8_LAST;
  assign rx_last = nine_bit ? FRAME9_LAST : FRAME8_LAST;

  // Transmitter. A write while busy restarts with the new byte.
  assign tx_done_set = ((tx_st_q == TX_SHIFT) && cyc_end && (tx_bit_q[2:0] == SHIFT_BITS_LAST)) ||
                       ((tx_st_q == TX_ASYNC) && tx_tick && (tx_sub_q == OVERSAMPLE) &&
                        (tx_bit_q == tx_last - 4'h1));

  always_ff @(posedge SYS_CLK_IN or negedge RST_B_IN) begin
    if (!RST_B_IN) begin
      tx_st_q  <= TX_IDLE;
      tx_sh_q  <= 11'h7FF;
      tx_sub_q <= 4'h0;
      tx_bit_q <= 4'h0;
    end else if (buf_write) begin
      tx_sub_q <= 4'h0;
      tx_bit_q <= 4'h0;
      if (mode == MODE_SHIFT) begin
        tx_st_q <= TX_ARM;
        tx_sh_q <= {3'h7, PWDATA_IN[7:0]};
      end else begin
        tx_st_q <= TX_ASYNC;
        tx_sh_q <= {1'b1, nine_bit ? control_q[BIT_TX_NINTH] : 1'b1,
                    PWDATA_IN[7:0], 1'b0};
      end
    end else begin
      case (tx_st_q)
        TX_ARM: if (cyc_end) tx_st_q <= TX_SHIFT;
        TX_SHIFT: begin
          if (cyc_end) begin
            tx_sh_q  <= {1'b1, tx_sh_q[10:1]};
            tx_bit_q <= tx_bit_q + 4'h1;
            if (tx_bit_q[2:0] == SHIFT_BITS_LAST) begin
              tx_st_q <= TX_IDLE;
            end
          end
        end
        TX_ASYNC: begin
          if (tx_tick) begin
            tx_sub_q <= tx_sub_q + 4'h1;
            if (tx_sub_q == OVERSAMPLE) begin
              tx_sh_q  <= {1'b1, tx_sh_q[10:1]};
              tx_bit_q <= tx_bit_q + 4'h1;
              if (tx_bit_q == tx_last) begin
                tx_st_q <= TX_IDLE;
              end
            end
          end
        end
        default: tx_st_q <= TX_IDLE;
      endcase
    end
  end

  // Receiver. The buffer keeps its byte while receive done is set; a later frame is then dropped.
  assign rx_stop_seen = (rx_st_q == RX_ASYNC) && rx_tick && (rx_sub_q == OVERSAMPLE_MID) &&
                        (rx_bit_q == rx_last);
  always_comb begin
    rx_accept = 1'b0;
    if ((rx_st_q == RX_SHIFT) && cyc_end && (rx_bit_q[2:0] == SHIFT_BITS_LAST)) begin
      rx_accept = !control_q[BIT_RX_DONE];
    end else if (rx_stop_seen && !control_q[BIT_RX_DONE]) begin
      if (nine_bit) begin
        rx_accept = !control_q[BIT_FILTER] || rx_ninth_q;
      end else begin
        rx_accept = !control_q[BIT_FILTER] || rxd_sync_q;
      end
    end
  end
  assign rx_done_set = rx_accept;
  // In eight-bit mode the stop bit is sampled on the very tick that accepts the frame.
  assign rx_ninth_in = (mode == MODE_VAR8) ? rxd_sync_q : rx_ninth_q;

  always_ff @(posedge SYS_CLK_IN or negedge RST_B_IN) begin
    if (!RST_B_IN) begin
      rx_buffer_q <= 8'h00;
    end else if (rx_accept) begin
      rx_buffer_q <= (rx_st_q == RX_SHIFT) ? {rx_ninth_q, rx_sh_q[7:1]} : rx_sh_q;
    end
  end

  always_ff @(posedge SYS_CLK_IN or negedge RST_B_IN) begin
    if (!RST_B_IN) begin
      rx_st_q    <= RX_IDLE;
      rx_sh_q    <= 8'h00;
      rx_sub_q   <= 4'h0;
      rx_bit_q   <= 4'h0;
      rx_ninth_q <= 1'b0;
    end else begin
      case (rx_st_q)
        RX_IDLE: begin
          rx_sub_q <= 4'h0;
          rx_bit_q <= 4'h0;
          if (control_q[BIT_RX_ENABLE]) begin
            if (mode == MODE_SHIFT) begin
              if (!control_q[BIT_RX_DONE] && (tx_st_q == TX_IDLE)) begin
                rx_st_q <= RX_ARM;
              end
            end else if (!rxd_sync_q && rxd_prev_q) begin
              rx_st_q <= RX_ASYNC;
            end
          end
        end
        RX_ARM: if (cyc_end) rx_st_q <= RX_SHIFT;
        RX_SHIFT: begin
          if (cyc_q == SHIFT_RISE) rx_ninth_q <= rxd_sync_q;
          if (cyc_end) begin
            rx_sh_q  <= {rx_ninth_q, rx_sh_q[7:1]};
            rx_bit_q <= rx_bit_q + 4'h1;
            if (rx_bit_q[2:0] == SHIFT_BITS_LAST) begin
              rx_st_q <= RX_IDLE;
            end
          end
        end
        RX_ASYNC: begin
          if (rx_tick) begin
            rx_sub_q <= rx_sub_q + 4'h1;
            if (rx_sub_q == OVERSAMPLE_MID) begin
              rx_bit_q <= rx_bit_q + 4'h1;
              if ((rx_bit_q == 4'h0) && rxd_sync_q) begin
                rx_st_q <= RX_IDLE;
              end else if (rx_bit_q == rx_last) begin
                rx_st_q <= RX_IDLE;
              end else if (rx_bit_q <= 4'h8 && rx_bit_q != 4'h0) begin
                rx_sh_q <= {rxd_sync_q, rx_sh_q[7:1]};
              end
              if ((rx_bit_q == 4'h9) || (!nine_bit && (rx_bit_q == rx_last))) begin
                rx_ninth_q <= rxd_sync_q;
              end
            end
          end
          if (!control_q[BIT_RX_ENABLE] || (mode == MODE_SHIFT)) begin
            rx_st_q <= RX_IDLE;
          end
        end
        default: rx_st_q <= RX_IDLE;
      endcase
    end
  end

  // Pins are registered; in shift mode the data pin carries the byte and the
  // clock pin is low for the first half of each twelve-clock cycle.
  always_ff @(posedge SYS_CLK_IN or negedge RST_B_IN) begin
    if (!RST_B_IN) begin
      txd_q     <= 1'b1;
      rxd_out_q <= 1'b1;
      rxd_oe_q  <= 1'b0;
      irq_q     <= 1'b0;
    end else begin
      irq_q     <= control_q[BIT_TX_DONE] || control_q[BIT_RX_DONE];
      rxd_out_q <= tx_sh_q[0];
      rxd_oe_q  <= (tx_st_q == TX_SHIFT);
      if ((tx_st_q == TX_SHIFT) || (rx_st_q == RX_SHIFT)) begin
        txd_q <= (cyc_q >= SHIFT_RISE);
      end else if (tx_st_q == TX_ASYNC) begin
        txd_q <= tx_sh_q[0];
      end else begin
        txd_q <= 1'b1;
      end
    end
  end

  assign PRDATA_OUT  = prdata_q;
  assign PREADY_OUT  = pready_q;
  assign PSLVERR_OUT = pslverr_q;
  assign TXD_OUT     = txd_q;
  assign RXD_OUT     = rxd_out_q;
  assign RXD_OE_OUT  = rxd_oe_q;
  assign IRQ_OUT     = irq_q;

  chk_pready_single: assert property (@(posedge SYS_CLK_IN) disable iff (!RST_B_IN)
    pready_q |=> !pready_q) else $error("Ready held longer than one cycle.");
  chk_write_starts_tx: assert property (@(posedge SYS_CLK_IN) disable iff (!RST_B_IN)
    buf_write |=> (tx_st_q != TX_IDLE)) else $error("Buffer write did not start transmit.");
  chk_tx_done_flag: assert property (@(posedge SYS_CLK_IN) disable iff (!RST_B_IN)
    tx_done_set |=> control_q[BIT_TX_DONE]) else $error("Transmit done flag not set.");
  chk_filter_ninth: assert property (@(posedge SYS_CLK_IN) disable iff (!RST_B_IN)
    (rx_stop_seen && nine_bit && control_q[BIT_FILTER] && !rx_ninth_q) |-> !rx_done_set)
    else $error("Filtered frame raised receive done.");
  chk_filter_stop: assert property (@(posedge SYS_CLK_IN) disable iff (!RST_B_IN)
    (rx_stop_seen && !nine_bit && control_q[BIT_FILTER] && !rxd_sync_q) |-> !rx_done_set)
    else $error("Bad stop bit raised receive done.");
  chk_shift_rate: assert property (@(posedge SYS_CLK_IN) disable iff (!RST_B_IN)
    (tx_st_q == TX_SHIFT) && !buf_write && !cyc_end |=> $stable(tx_sh_q))
    else $error("Shift-mode data moved off the machine cycle.");
  chk_rx_needs_enable: assert property (@(posedge SYS_CLK_IN) disable iff (!RST_B_IN)
    (rx_st_q == RX_IDLE) && !control_q[BIT_RX_ENABLE] |=> (rx_st_q == RX_IDLE))
    else $error("Reception began while disabled.");
  chk_ninth_stored: assert property (@(posedge SYS_CLK_IN) disable iff (!RST_B_IN)
    rx_accept && !ctl_write |=> (control_q[BIT_RX_NINTH] == $past(rx_ninth_in)))
    else $error("Ninth bit not stored.");
  chk_idle_line_high: assert property (@(posedge SYS_CLK_IN) disable iff (!RST_B_IN)
    (tx_st_q == TX_IDLE) && (rx_st_q != RX_SHIFT) |=> txd_q)
    else $error("Transmit line not idle high.");
  chk_irq_follows: assert property (@(posedge SYS_CLK_IN) disable iff (!RST_B_IN)
    control_q[BIT_RX_DONE] |=> irq_q) else $error("Interrupt request missing.");

  cov_async_tx_done: cover property (@(posedge SYS_CLK_IN) disable iff (!RST_B_IN)
    (tx_st_q == TX_ASYNC) && tx_done_set);
  cov_async_rx_accept: cover property (@(posedge SYS_CLK_IN) disable iff (!RST_B_IN)
    rx_stop_seen && rx_accept && nine_bit);
  cov_shift_rx: cover property (@(posedge SYS_CLK_IN) disable iff (!RST_B_IN)
    (rx_st_q == RX_SHIFT) && rx_accept);
  cov_duplex: cover property (@(posedge SYS_CLK_IN) disable iff (!RST_B_IN)
    (tx_st_q == TX_ASYNC) && (rx_st_q == RX_ASYNC));
endmodule : spu_serial_port

// ===== verification/spu_remote_model.sv
/*
  Remote serial partner for the four-mode serial port: sends and captures
  asynchronous frames, and feeds or captures shift-register mode bytes.
  Assumes bit times are given in system clocks and the data line idles high.
*/
`timescale 1ns/10ps
module spu_remote_model (
  input  wire logic sys_clk_in,
  input  wire logic txd_in,
  input  wire logic pin_in,
  input  wire logic pin_oe_in,
  output logic      rxd_out
);
  // The line is always driven, high between frames, so it never floats.
  initial rxd_out = 1'b1;

  task automatic hold(input int n);
    repeat (n) @(posedge sys_clk_in);
  endtask : hold

  task automatic send(input logic [7:0] d, input logic nb, input logic nine,
                      input logic stop, input int bt);
    rxd_out <= 1'b0;
    hold(bt);
    for (int i = 0; i < 8; i++) begin
      rxd_out <= d[i];
      hold(bt);
    end
    if (nine) begin
      rxd_out <= nb;
      hold(bt);
    end
    rxd_out <= stop;
    hold(bt);
    rxd_out <= 1'b1;
  endtask : send

  // Samples at mid-bit, so a small tick phase error is tolerated.
  task automatic recv(output logic [7:0] d, output logic nb, output logic stop,
                      input logic nine, input int bt);
    @(negedge txd_in);
    hold(bt / 2);
    for (int i = 0; i < 8; i++) begin
      hold(bt);
      d[i] = txd_in;
    end
    nb = 1'b0;
    if (nine) begin
      hold(bt);
      nb = txd_in;
    end
    hold(bt);
    stop = txd_in;
  endtask : recv

  task automatic shift_cap(output logic [7:0] d, output int per);
    time t0;
    for (int i = 0; i < 8; i++) begin
      @(posedge txd_in iff pin_oe_in);
      if (i == 0) t0 = $time;
      if (i == 1) per = int'($time - t0);
      hold(2);
      d[i] = pin_in;
    end
  endtask : shift_cap

  task automatic shift_feed(input logic [7:0] d);
    for (int i = 0; i < 8; i++) begin
      @(negedge txd_in);
      rxd_out <= d[i];
    end
    @(posedge txd_in);
    hold(3);
    rxd_out <= 1'b1;
  endtask : shift_feed
endmodule : spu_remote_model

// ===== verification/tb_serial_port_four_mode_uart.sv
/*
  Self-checking bench for the four-mode serial port: APB register access,
  frames in every mode and shift-register transfers.
  Assumes the package, the design and the remote model are compiled first.
*/
`timescale 1ns/10ps
`define SPU_CHK(g, e) begin num_checks++; if ((g) !== (e)) begin failures++; \
  $display("unexpected at %0t: got %h expected %h", $time, (g), (e)); end end
module tb_serial_port_four_mode_uart;
  import spu_pkg::*;
  logic        SYS_CLK_IN;
  logic        RST_B_IN;
  logic        PSEL_IN;
  logic        PENABLE_IN;
  logic        PWRITE_IN;
  logic [7:0]  PADDR_IN;
  logic [31:0] PWDATA_IN;
  logic [31:0] PRDATA_OUT;
  logic        PREADY_OUT;
  logic        PSLVERR_OUT;
  logic        TMR_A_OVF_IN;
  logic        TMR_B_OVF_IN;
  wire logic   RXD_IN;
  logic        RXD_OUT;
  logic        RXD_OE_OUT;
  logic        TXD_OUT;
  logic        IRQ_OUT;
  logic        line_w;
  logic [2:0]  tmr_cnt;
  logic [31:0] rdata;
  logic        rerr;
  logic [7:0]  d;
  logic        nb;
  logic        sb;
  int          per;
  int          failures;
  int          num_checks;

  // The pin carries the port's own drive whenever it enables it.
  assign RXD_IN = RXD_OE_OUT ? RXD_OUT : line_w;

  spu_serial_port dut (.SYS_CLK_IN(SYS_CLK_IN), .RST_B_IN(RST_B_IN), .PSEL_IN(PSEL_IN),
    .PENABLE_IN(PENABLE_IN), .PWRITE_IN(PWRITE_IN), .PADDR_IN(PADDR_IN),
    .PWDATA_IN(PWDATA_IN), .PRDATA_OUT(PRDATA_OUT), .PREADY_OUT(PREADY_OUT),
    .PSLVERR_OUT(PSLVERR_OUT), .TMR_A_OVF_IN(TMR_A_OVF_IN), .TMR_B_OVF_IN(TMR_B_OVF_IN),
    .RXD_IN(RXD_IN), .RXD_OUT(RXD_OUT), .RXD_OE_OUT(RXD_OE_OUT), .TXD_OUT(TXD_OUT),
    .IRQ_OUT(IRQ_OUT));

  spu_remote_model model (.sys_clk_in(SYS_CLK_IN), .txd_in(TXD_OUT), .pin_in(RXD_IN),
    .pin_oe_in(RXD_OE_OUT), .rxd_out(line_w));

  initial begin
    SYS_CLK_IN = 1'b0;
    forever #12.5 SYS_CLK_IN = ~SYS_CLK_IN;
  end

  // Timer A overflows every 2 clocks and timer B every 8, to keep frames short.
  always @(posedge SYS_CLK_IN) begin
    tmr_cnt      <= tmr_cnt + 3'h1;
    TMR_A_OVF_IN <= ~tmr_cnt[0];
    TMR_B_OVF_IN <= (tmr_cnt == 3'h7);
  end

  task automatic test_done();
    if (failures == 0 && num_checks > 0) begin
      $display("bench passed");
    end else begin
      $display("bench failed");
    end
    $finish;
  endtask : test_done

  task automatic apb(input logic w, input logic [7:0] a, input logic [31:0] wd);
    int n;
    @(posedge SYS_CLK_IN);
    PSEL_IN    <= 1'b1;
    PENABLE_IN <= 1'b0;
    PWRITE_IN  <= w;
    PADDR_IN   <= a;
    PWDATA_IN  <= wd;
    @(posedge SYS_CLK_IN);
    PENABLE_IN <= 1'b1;
    n = 0;
    do begin
      @(posedge SYS_CLK_IN);
      n++;
    end while (PREADY_OUT !== 1'b1 && n < 64);
    if (n >= 64) begin
      failures++;
      test_done();
    end
    rdata = PRDATA_OUT;
    rerr  = PSLVERR_OUT;
    PSEL_IN    <= 1'b0;
    PENABLE_IN <= 1'b0;
  endtask : apb

  task automatic wr(input logic [7:0] a, input logic [7:0] v);
    apb(1'b1, a, {24'h0, v});
  endtask : wr

  task automatic rdc(input logic [7:0] a, input logic [31:0] e);
    apb(1'b0, a, 32'h0);
    `SPU_CHK(rdata, e)
  endtask : rdc

  initial begin
    RST_B_IN     = 1'b0;
    PSEL_IN      = 1'b0;
    PENABLE_IN   = 1'b0;
    PWRITE_IN    = 1'b0;
    PADDR_IN     = 8'h00;
    PWDATA_IN    = 32'h0;
    TMR_A_OVF_IN = 1'b0;
    TMR_B_OVF_IN = 1'b0;
    tmr_cnt      = 3'h0;
    failures     = 0;
    num_checks   = 0;
    repeat (12) @(posedge SYS_CLK_IN);
    RST_B_IN <= 1'b1;
    rdc(ADDR_CONTROL, 32'h0);
    rdc(ADDR_RATE, 32'h0);
    rdc(8'h0C, 32'h0);
    `SPU_CHK(rerr, 1'b1)
    wr(ADDR_CONTROL, 8'h98);
    fork
      model.recv(d, nb, sb, 1'b1, 64);
      wr(ADDR_BUFFER, 8'hA5);
      model.send(8'h3C, 1'b0, 1'b1, 1'b1, 64);
    join
    `SPU_CHK({nb, d, sb}, 10'h34B)
    rdc(ADDR_CONTROL, 32'h9B);
    rdc(ADDR_BUFFER, 32'h3C);
    `SPU_CHK(IRQ_OUT, 1'b1)
    // A second frame completes while receive done from the first is still set.
    model.send(8'h55, 1'b1, 1'b1, 1'b1, 64);
    rdc(ADDR_BUFFER, 32'h3C);
    rdc(ADDR_CONTROL, 32'h9B);
    wr(ADDR_CONTROL, 8'hB0);
    wr(ADDR_RATE, 8'h01);
    `SPU_CHK(IRQ_OUT, 1'b0)
    model.send(8'h22, 1'b1, 1'b1, 1'b1, 32);
    rdc(ADDR_CONTROL, 32'hB5);
    wr(ADDR_CONTROL, 8'hB0);
    model.send(8'h11, 1'b0, 1'b1, 1'b1, 32);
    apb(1'b0, ADDR_CONTROL, 32'h0);
    `SPU_CHK(rdata[0], 1'b0)
    rdc(ADDR_BUFFER, 32'h22);
    wr(ADDR_CONTROL, 8'h50);
    fork
      model.recv(d, nb, sb, 1'b0, 32);
      wr(ADDR_BUFFER, 8'h69);
      model.send(8'h96, 1'b0, 1'b0, 1'b1, 32);
    join
    `SPU_CHK({d, sb}, 9'h0D3)
    rdc(ADDR_CONTROL, 32'h57);
    rdc(ADDR_BUFFER, 32'h96);
    wr(ADDR_CONTROL, 8'h40);
    model.send(8'h33, 1'b0, 1'b0, 1'b1, 32);
    rdc(ADDR_CONTROL, 32'h40);
    wr(ADDR_CONTROL, 8'h70);
    model.send(8'h0F, 1'b0, 1'b0, 1'b0, 32);
    apb(1'b0, ADDR_CONTROL, 32'h0);
    `SPU_CHK(rdata[0], 1'b0)
    wr(ADDR_RATE, 8'h06);
    rdc(ADDR_RATE, 32'h06);
    wr(ADDR_CONTROL, 8'hD8);
    fork
      model.recv(d, nb, sb, 1'b1, 128);
      wr(ADDR_BUFFER, 8'hC3);
      model.send(8'h5A, 1'b1, 1'b1, 1'b0, 128);
    join
    `SPU_CHK({nb, d}, 9'h1C3)
    rdc(ADDR_CONTROL, 32'hDF);
    rdc(ADDR_BUFFER, 32'h5A);
    wr(ADDR_CONTROL, 8'h00);
    fork
      model.shift_cap(d, per);
      wr(ADDR_BUFFER, 8'hE7);
    join
    `SPU_CHK(d, 8'hE7)
    `SPU_CHK(per, 300)
    repeat (12) @(posedge SYS_CLK_IN);
    rdc(ADDR_CONTROL, 32'h02);
    fork
      model.shift_feed(8'h4B);
      wr(ADDR_CONTROL, 8'h10);
    join
    repeat (12) @(posedge SYS_CLK_IN);
    rdc(ADDR_CONTROL, 32'h11);
    rdc(ADDR_BUFFER, 32'h4B);
    test_done();
  end

  // The whole sequence needs about 5000 clocks; this allows for hangs only.
  initial begin
    repeat (40000) @(posedge SYS_CLK_IN);
    failures++;
    test_done();
  end
endmodule : tb_serial_port_four_mode_uart
